// ===== core/boot_pkg.sv
// boot loader constants: flash command, address, strap levels, timing
// assumes a 100 MHz system clock and a 6 ns-class serial link clock
package boot_pkg;
   localparam logic [7:0]  FLASH_READ_OPCODE  = 8'hEB;
   localparam logic [23:0] FLASH_START_ADDR   = 24'h000000;
   localparam int          ADDR_BITS          = 24;
   localparam int          OPCODE_BITS        = 8;
   localparam int          MODE_NIBBLES       = 2;
   localparam int          DUMMY_NIBBLES      = 4;
   localparam logic        STRAP_SLAVE        = 1'b1;
   localparam int          CLK_SYS_MHZ        = 100;
   localparam int          FLASH_CLK_MHZ_MAX  = 12;
   // half period of the flash clock, rounded up so it never runs fast
   localparam int          FLASH_HALF_CYCLES  =
      (CLK_SYS_MHZ + 2 * FLASH_CLK_MHZ_MAX - 1) / (2 * FLASH_CLK_MHZ_MAX);
   localparam int          POR_CYCLES         = 16;
   localparam int          BYTE_BITS          = 8;
   localparam int          NIBBLE_BITS        = 4;
   localparam logic [7:0]  MISO_IDLE_BYTE     = 8'hFF;

   typedef enum logic [2:0]
   {
      ST_STRAP  = 3'b000,
      ST_SELECT = 3'b001,
      ST_CMD    = 3'b011,
      ST_ADDR   = 3'b010,
      ST_DUMMY  = 3'b110,
      ST_DATA   = 3'b111,
      ST_SLAVE  = 3'b101
   } boot_state_t;
endpackage

// ===== core/byte_stream_if.sv
// valid/ready byte stream between the loader and its output buffer
// assumes both ends run on clk_sys
`timescale 1ns/1ns
interface byte_stream_if;
   logic       valid;
   logic       ready;
   logic [7:0] data;
   modport src
   (
      output valid,
      output data,
      input  ready
   );
   modport dst
   (
      input  valid,
      input  data,
      output ready
   );
endinterface

// ===== core/skid_buffer.sv
// two-entry buffer with valid/ready on both sides
// assumes a single clock; the output data comes from a register
`timescale 1ns/1ns
module skid_buffer
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
)
(
   input  wire logic             clk_sys,    // system clock
   input  wire logic             rstn,       // async reset, active low
   byte_stream_if.dst            in_s,       // filling side
   output logic                  out_valid,  // word available
   output logic [WIDTH-1:0]      out_data,   // word
   input  wire logic             out_ready   // drainer accepts
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic [WIDTH-1:0] data_q, data_d;
   logic             vld_q, vld_d;
   logic             push, pop;

   function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
      inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   always_comb
   begin
      in_s.ready = (cnt_q != CW'(DEPTH));
      push       = in_s.valid && in_s.ready;
      pop        = (cnt_q != '0) && (!vld_q || out_ready);
      wr_d       = push ? inc(wr_q) : wr_q;
      rd_d       = pop ? inc(rd_q) : rd_q;
      cnt_d      = cnt_q + CW'(push) - CW'(pop);
      vld_d      = pop ? 1'b1 : (out_ready ? 1'b0 : vld_q);
      data_d     = pop ? mem_q[rd_q] : data_q;
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         wr_q   <= '0;
         rd_q   <= '0;
         cnt_q  <= '0;
         vld_q  <= 1'b0;
         data_q <= '0;
      end
      else
      begin
         wr_q   <= wr_d;
         rd_q   <= rd_d;
         cnt_q  <= cnt_d;
         vld_q  <= vld_d;
         data_q <= data_d;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_q[wr_q] <= in_s.data;
   end

   assign out_valid = vld_q;
   assign out_data  = data_q;
endmodule

// ===== core/boot_loader.sv
// boot-mode select and firmware image loader
// assumes clk_sys is free-running before rstn rises; spi_clk from the host
// only toggles while its chip select is low
`timescale 1ns/1ns
module boot_loader
(
   input  wire logic       clk_sys,        // system clock, 100 MHz
   input  wire logic       rstn,           // reset pin, active low
   input  wire logic       spi_clk,        // clock pin as input (link clock)
   output logic            clk_pin_out,    // clock pin as flash clock
   output logic            clk_pin_oe,     // clock pin drive enable
   output logic            flash_cs_n,     // flash chip select, active low
   output logic            flash_cs_oe,    // flash select drive enable
   input  wire logic [3:0] flash_din,      // flash data 3..0 in; 1 = strap
   output logic [3:0]      flash_dout,     // flash data out
   output logic [3:0]      flash_oe,       // flash data drive enables
   input  wire logic       spi_cs_n,       // host chip select, active low
   input  wire logic       spi_mosi,       // host to device data
   output logic            spi_miso,       // device to host data
   output logic            spi_miso_oe,    // miso drive enable
   output logic            slave_mode,     // strap chose host boot
   output logic            core_rst_n,     // reset to rest of chip, low
   output logic            img_valid,      // image byte available
   output logic [7:0]      img_data,       // image byte
   input  wire logic       img_ready       // consumer accepts byte
);
   // ********************************************************************
   // reset: on-chip power-on counter ORed with the pin
   // ********************************************************************
   localparam int PCW = $clog2(boot_pkg::POR_CYCLES + 1);
   logic [PCW-1:0] por_q, por_d;
   logic           rst_q, rst_d;

   always_comb
   begin
      por_d = (por_q == PCW'(boot_pkg::POR_CYCLES)) ? por_q
                                                    : por_q + PCW'(1);
      rst_d = (por_q == PCW'(boot_pkg::POR_CYCLES));
   end

   // por_q restarts on every pin reset, so both sources give one state
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         por_q <= '0;
         rst_q <= 1'b0;
      end
      else
      begin
         por_q <= por_d;
         rst_q <= rst_d;
      end
   end

   // ********************************************************************
   // strap sampling and flash master sequencer
   // ********************************************************************
   boot_pkg::boot_state_t st_q, st_d;
   logic [2:0]  strap_sync_q;
   logic [5:0]  cnt_q, cnt_d;
   logic [3:0]  div_q, div_d;
   logic        sclk_q, sclk_d;
   logic        cs_q, cs_d;
   logic        mode_q, mode_d;
   logic [31:0] sh_q, sh_d;
   logic [3:0]  lo_q, lo_d;
   logic        half_q, half_d;
   logic [3:0]  dout_q, dout_d;
   logic [3:0]  oe_q, oe_d;
   logic        rise, fall;
   byte_stream_if bs ();
   logic        f_valid, f_valid_q;
   logic [7:0]  f_data, f_data_q;

   always_comb
   begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      mode_d = mode_q;
      sh_d   = sh_q;
      lo_d   = lo_q;
      half_d = half_q;
      cs_d   = cs_q;
      dout_d = dout_q;
      oe_d   = oe_q;
      f_valid = 1'b0;
      f_data  = '0;
      div_d  = div_q;
      sclk_d = sclk_q;
      rise   = 1'b0;
      fall   = 1'b0;
      if (!cs_q && bs.ready)
      begin
         if (div_q == 4'(boot_pkg::FLASH_HALF_CYCLES - 1))
         begin
            div_d  = '0;
            sclk_d = !sclk_q;
            rise   = !sclk_q;
            fall   = sclk_q;
         end
         else
            div_d = div_q + 4'h1;
      end
      case (st_q)
         boot_pkg::ST_STRAP:
            if (strap_sync_q[2] == strap_sync_q[1])
            begin
               mode_d = (strap_sync_q[2]
                         == boot_pkg::STRAP_SLAVE);
               st_d   = boot_pkg::ST_SELECT;
            end
         boot_pkg::ST_SELECT:
            if (mode_q)
               st_d = boot_pkg::ST_SLAVE;
            else
            begin
               // opcode serial on data0, then 24-bit address zero
               cnt_d  = 6'(boot_pkg::OPCODE_BITS);
               cs_d   = 1'b0;
               oe_d   = 4'h1;
               dout_d = {3'h0, boot_pkg::FLASH_READ_OPCODE[7]};
               // msb is already on the pin; pad below the address so the
               // address nibbles line up once the opcode has shifted out
               sh_d   = {boot_pkg::FLASH_READ_OPCODE[6:0],
                         boot_pkg::FLASH_START_ADDR, 1'b0};
               st_d   = boot_pkg::ST_CMD;
            end
         boot_pkg::ST_CMD:
            if (fall)
            begin
               cnt_d = cnt_q - 6'h1;
               if (cnt_q == 6'h1)
               begin
                  oe_d   = 4'hF;
                  dout_d = sh_q[31:28];
                  sh_d   = {sh_q[27:0], 4'h0};
                  cnt_d  = 6'(boot_pkg::ADDR_BITS / boot_pkg::NIBBLE_BITS
                              + boot_pkg::MODE_NIBBLES);
                  st_d   = boot_pkg::ST_ADDR;
               end
               else
               begin
                  dout_d = {3'h0, sh_q[31]};
                  sh_d   = {sh_q[30:0], 1'b0};
               end
            end
         boot_pkg::ST_ADDR:
            if (fall)
            begin
               cnt_d  = cnt_q - 6'h1;
               dout_d = sh_q[31:28];
               sh_d   = {sh_q[27:0], 4'h0};
               if (cnt_q == 6'h1)
               begin
                  oe_d  = 4'h0;
                  cnt_d = 6'(boot_pkg::DUMMY_NIBBLES);
                  st_d  = boot_pkg::ST_DUMMY;
               end
            end
         boot_pkg::ST_DUMMY:
            if (fall)
            begin
               cnt_d = cnt_q - 6'h1;
               if (cnt_q == 6'h1)
               begin
                  half_d = 1'b0;
                  st_d   = boot_pkg::ST_DATA;
               end
            end
         boot_pkg::ST_DATA:
            if (rise)
            begin
               half_d = !half_q;
               if (!half_q)
                  lo_d = flash_din;
               else
               begin
                  f_valid = 1'b1;
                  f_data  = {flash_din, lo_q};
               end
            end
         boot_pkg::ST_SLAVE:
         begin
            f_valid = f_valid_q;
            f_data  = f_data_q;
         end
         default:
            st_d = boot_pkg::ST_STRAP;
      endcase
   end

   // strap passes three flops; released logic waits for two to agree
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_sync_q <= '0;
         st_q   <= boot_pkg::ST_STRAP;
         cnt_q  <= '0;
         div_q  <= '0;
         sclk_q <= 1'b0;
         cs_q   <= 1'b1;
         mode_q <= 1'b0;
         sh_q   <= '0;
         lo_q   <= '0;
         half_q <= 1'b0;
         dout_q <= '0;
         oe_q   <= '0;
      end
      else
      begin
         strap_sync_q <= {strap_sync_q[1:0], flash_din[1]};
         st_q   <= rst_q ? st_d : boot_pkg::ST_STRAP;
         cnt_q  <= cnt_d;
         div_q  <= div_d;
         sclk_q <= sclk_d;
         cs_q   <= cs_d;
         mode_q <= mode_d;
         sh_q   <= sh_d;
         lo_q   <= lo_d;
         half_q <= half_d;
         dout_q <= dout_d;
         oe_q   <= oe_d;
      end
   end

   // ********************************************************************
   // host link: bytes shifted in on spi_clk, handed over by toggle
   // ********************************************************************
   logic [2:0] bitn_q;
   logic [7:0] rx_q, hold_q;
   logic       tgl_q;
   logic [2:0] tgl_sync_q;
   logic [2:0] cs_sync_q;
   logic       cs_n_q;

   // reset by chip select so no clock edge is needed after a frame
   always_ff @(posedge spi_clk or posedge spi_cs_n)
   begin
      if (spi_cs_n)
         bitn_q <= '0;
      else
         bitn_q <= bitn_q + 3'h1;
   end

   // the shift register needs no reset; only whole bytes leave it
   always_ff @(posedge spi_clk)
   begin
      if (!spi_cs_n)
         rx_q <= {spi_mosi, rx_q[7:1]};
   end

   always_ff @(posedge spi_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tgl_q  <= 1'b0;
         hold_q <= '0;
      end
      else if (!spi_cs_n && bitn_q == 3'h7)
      begin
         tgl_q  <= !tgl_q;
         hold_q <= {spi_mosi, rx_q[7:1]};
      end
   end

   // hold_q is stable for a whole byte time after each toggle
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         tgl_sync_q <= '0;
         cs_sync_q  <= '1;
         cs_n_q     <= 1'b1;
         f_valid_q  <= 1'b0;
         f_data_q   <= '0;
      end
      else
      begin
         tgl_sync_q <= {tgl_sync_q[1:0], tgl_q};
         // host select is a pin: it counts once two stages agree
         cs_sync_q  <= {cs_sync_q[1:0], spi_cs_n};
         cs_n_q     <= (cs_sync_q[2] == cs_sync_q[1]) ? cs_sync_q[2]
                                                      : cs_n_q;
         f_valid_q  <= mode_q && (tgl_sync_q[2] != tgl_sync_q[1]);
         f_data_q   <= hold_q;
      end
   end

   assign bs.valid = f_valid;
   assign bs.data  = f_data;

   skid_buffer #(.WIDTH(8), .DEPTH(2)) u_buf
   (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .in_s      (bs),
      .out_valid (img_valid),
      .out_data  (img_data),
      .out_ready (img_ready)
   );

   // ********************************************************************
   // pin drive: flops only
   // ********************************************************************
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         clk_pin_out <= 1'b0;
         clk_pin_oe  <= 1'b0;
         flash_cs_n  <= 1'b1;
         flash_cs_oe <= 1'b0;
         flash_dout  <= '0;
         flash_oe    <= '0;
         spi_miso    <= 1'b1;
         spi_miso_oe <= 1'b0;
         slave_mode  <= 1'b0;
         core_rst_n  <= 1'b0;
      end
      else
      begin
         clk_pin_out <= sclk_q;
         clk_pin_oe  <= rst_q && !mode_q
                        && st_q != boot_pkg::ST_STRAP;
         flash_cs_n  <= cs_q;
         flash_cs_oe <= rst_q && !mode_q && st_q != boot_pkg::ST_STRAP;
         flash_dout  <= dout_q;
         flash_oe    <= mode_q ? 4'h0 : oe_q;
         spi_miso    <= boot_pkg::MISO_IDLE_BYTE[0];
         spi_miso_oe <= mode_q && !cs_n_q;
         slave_mode  <= mode_q;
         core_rst_n  <= rst_q;
      end
   end
endmodule

// ===== verification/boot_loader_props.sv
// assertions on the loader pins and image stream
// assumes a bind onto boot_loader, clk_sys domain only
`timescale 1ns/1ns
module boot_loader_props
(
   input wire logic       clk_sys,      // clock
   input wire logic       rstn,         // reset, low
   input wire logic       clk_pin_out,  // flash clock
   input wire logic       clk_pin_oe,   // its enable
   input wire logic       flash_cs_n,   // flash select
   input wire logic       flash_cs_oe,  // its enable
   input wire logic [3:0] flash_dout,   // flash data out
   input wire logic [3:0] flash_oe,     // data enables
   input wire logic       slave_mode,   // host boot
   input wire logic       core_rst_n,   // core reset
   input wire logic       img_valid,    // byte valid
   input wire logic [7:0] img_data,     // byte
   input wire logic       img_ready     // byte taken
);
   // ********************
   // helpers and checks
   // ********************
   logic [7:0] por_q;
   logic [7:0] por_d;
   always_comb por_d = core_rst_n ? por_q : por_q + 8'h01;
   always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn) por_q <= 8'h00;
      else por_q <= por_d;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_cs_fall;
      $fell(flash_cs_n) && !slave_mode;
   endsequence
   sequence s_msb_one;
      $rose(clk_pin_out) && flash_dout[0] && flash_oe[0];
   endsequence
   property p_opcode_msb;
      s_cs_fall |-> ##[0:20] s_msb_one;
   endproperty
   property p_por_len;
      $rose(core_rst_n) |-> por_q >= 8'h0F && por_q <= 8'h12;
   endproperty
   property p_slave_pins;
      slave_mode |-> !clk_pin_oe && !flash_cs_oe && flash_oe == 4'h0;
   endproperty
   property p_master_drv;
      !slave_mode && !flash_cs_n |-> flash_cs_oe && clk_pin_oe;
   endproperty
   property p_mode_hold;
      core_rst_n && $past(core_rst_n) |-> $stable(slave_mode);
   endproperty
   property p_core_quiet;
      !core_rst_n |-> !img_valid && flash_cs_n;
   endproperty
   property p_img_stand;
      img_valid && !img_ready |=> img_valid && $stable(img_data);
   endproperty
   property p_clk_high;
      $rose(clk_pin_out) |=> $stable(clk_pin_out)[*3];
   endproperty
   a_opcode_msb: assert property (p_opcode_msb)
      else $error("flash opcode msb not driven");
   a_por_len: assert property (p_por_len)
      else $error("core reset released at wrong count");
   a_slave_pins: assert property (p_slave_pins)
      else $error("pin driven in host boot");
   a_master_drv: assert property (p_master_drv)
      else $error("flash pins not driven in quad boot");
   a_mode_hold: assert property (p_mode_hold)
      else $error("boot mode changed after start");
   a_core_quiet: assert property (p_core_quiet)
      else $error("activity while core in reset");
   a_img_stand: assert property (p_img_stand)
      else $error("image byte dropped while stalled");
   a_clk_high: assert property (p_clk_high)
      else $error("flash clock high phase too short");
endmodule
bind boot_loader boot_loader_props u_props
(
   .clk_sys     (clk_sys),
   .rstn        (rstn),
   .clk_pin_out (clk_pin_out),
   .clk_pin_oe  (clk_pin_oe),
   .flash_cs_n  (flash_cs_n),
   .flash_cs_oe (flash_cs_oe),
   .flash_dout  (flash_dout),
   .flash_oe    (flash_oe),
   .slave_mode  (slave_mode),
   .core_rst_n  (core_rst_n),
   .img_valid   (img_valid),
   .img_data    (img_data),
   .img_ready   (img_ready)
);

// ===== verification/flash_model.sv
// quad flash partner: captures command, returns image nibbles
// assumes the device samples data on flash clock rises
`timescale 1ns/1ns
module flash_model
(
   input  wire logic       fclk,    // flash clock pin
   input  wire logic       cs_n,    // select pin
   input  wire logic [3:0] dq_in,   // device data
   output logic [3:0]      dq_out,  // flash data
   output logic [7:0]      opcode,  // captured command
   output logic [23:0]     addr,    // captured address
   output int              rises    // clock rises in frame
);
   logic [3:0] last_q = 4'hF;
   logic       drv = 1'b0;
   logic [7:0] b;
   int         idx;
   initial opcode = 8'h00;
   initial addr = 24'hFFFFFF;
   // each frame must capture its own command, not a stale one
   always @(posedge fclk or posedge cs_n)
      if (cs_n)
      begin
         rises  <= 0;
         opcode <= 8'h00;
         addr   <= 24'hFFFFFF;
      end
      else
      begin
         if (rises < 8) opcode <= {opcode[6:0], dq_in[0]};
         else if (rises < 14) addr <= {addr[19:0], dq_in};
         rises <= rises + 1;
      end
   // low nibble goes first; 20 rises cover command, address, mode, dummy
   always @(negedge fclk or posedge cs_n)
      if (cs_n) drv <= 1'b0;
      else if (rises >= 20)
      begin
         idx = rises - 20;
         b = 8'h3C + 8'h11 * 8'(idx / 2);
         last_q <= idx[0] ? b[7:4] : b[3:0];
         drv <= 1'b1;
      end
   // released lines flip; d1 rests low so the strap reads quad boot
   assign dq_out = drv ? last_q : {~last_q[3:2], 1'b0, ~last_q[0]};
endmodule

// ===== verification/testbench.sv
// self-checking bench for boot_loader with flash and host models
// assumes the strap is only changed deliberately
`timescale 1ns/1ns
module testbench;
   logic        clk_sys = 0, rstn = 0, host_clk = 0, spi_cs_n = 1;
   logic        spi_mosi = 0, img_ready = 0, strap_hi = 0;
   logic        clk_pin_out, clk_pin_oe, flash_cs_n, flash_cs_oe;
   logic        spi_miso, spi_miso_oe, slave_mode, core_rst_n, img_valid;
   logic [3:0]  flash_dout, flash_oe, fd;
   logic [7:0]  img_data, opcode;
   logic [23:0] addr;
   int          rises, n_errors = 0, check_count = 0, cycles = 0;
   wire         clk_pin = clk_pin_oe ? clk_pin_out : host_clk;
   wire         fcs = flash_cs_oe ? flash_cs_n : 1'b1;
   wire  [3:0]  flash_din =
      (flash_oe & flash_dout) | (~flash_oe & (strap_hi ? 4'hF : fd));
   boot_loader u_dut
   (
      .clk_sys(clk_sys), .rstn(rstn), .spi_clk(clk_pin),
      .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
      .flash_cs_n(flash_cs_n), .flash_cs_oe(flash_cs_oe),
      .flash_din(flash_din), .flash_dout(flash_dout),
      .flash_oe(flash_oe), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .slave_mode(slave_mode), .core_rst_n(core_rst_n),
      .img_valid(img_valid), .img_data(img_data), .img_ready(img_ready)
   );
   flash_model u_flash
   (
      .fclk(clk_pin), .cs_n(fcs), .dq_in(flash_din), .dq_out(fd),
      .opcode(opcode), .addr(addr), .rises(rises)
   );
   initial forever #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_errors++;
         end_of_test();
      end
   end
   // ********************
   // shared tasks
   // ********************
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic do_reset(logic strap);
      @(negedge clk_sys);
      rstn = 0;
      strap_hi = strap;
      img_ready = 0;
      repeat (16) @(negedge clk_sys);
      check("core_rst_n", core_rst_n, 0);
      rstn = 1;
      repeat (14) @(negedge clk_sys);
      check("core_rst_n", core_rst_n, 0);
      repeat (16) @(negedge clk_sys);
      check("core_rst_n", core_rst_n, 1);
   endtask
   task automatic pop(logic [7:0] exp);
      int k;
      k = 0;
      while (img_valid !== 1'b1 && k < 3000)
      begin
         @(negedge clk_sys);
         k++;
      end
      check("img_valid", img_valid, 1);
      check("img_data", img_data, exp);
      img_ready = 1;
      @(negedge clk_sys);
      img_ready = 0;
   endtask
   // host shifts lsb first, clock only inside the frame
   task automatic send_byte(logic [7:0] b);
      @(negedge clk_sys);
      spi_cs_n = 0;
      #3;
      for (int i = 0; i < 8; i++)
      begin
         spi_mosi = b[i];
         #3 host_clk = 1;
         #3 host_clk = 0;
      end
      check("spi_miso_oe", spi_miso_oe, 1);
      check("spi_miso", spi_miso, 1);
      #3 spi_cs_n = 1;
      spi_mosi = ~b[7];
   endtask
   // ********************
   // scenarios
   // ********************
   task automatic t_master();
      logic [7:0] e;
      int         r;
      do_reset(0);
      check("slave_mode", slave_mode, 0);
      check("spi_miso_oe", spi_miso_oe, 0);
      repeat (600) @(negedge clk_sys);
      check("opcode", opcode, 8'hEB);
      check("addr", addr, 24'h000000);
      check("clk_pin_oe", clk_pin_oe, 1);
      r = rises;
      repeat (50) @(negedge clk_sys);
      check("stalled rises", rises, r);
      e = 8'h3C;
      for (int i = 0; i < 6; i++)
      begin
         pop(e);
         e = e + 8'h11;
      end
   endtask
   task automatic t_slave();
      logic [7:0] t [4] = '{8'h01, 8'h80, 8'hC3, 8'h5A};
      do_reset(1);
      check("slave_mode", slave_mode, 1);
      check("clk_pin_oe", clk_pin_oe, 0);
      check("flash_oe", flash_oe, 0);
      check("flash_cs_oe", flash_cs_oe, 0);
      foreach (t[i])
      begin
         send_byte(t[i]);
         pop(t[i]);
      end
      strap_hi = 0;
      repeat (20) @(negedge clk_sys);
      check("slave_mode", slave_mode, 1);
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      t_master();
      t_slave();
      t_master();
      end_of_test();
   end
endmodule
